// ### rtl/capability_map.svh
`ifndef CAPABILITY_MAP_SVH
`define CAPABILITY_MAP_SVH

// Coprocessor register space address of the capability word
`define CAP3_REG_NUM 5'h10
`define CAP3_REG_SEL 3'h3

// Field positions inside the capability word
`define NEXT_PRESENT_BIT 31
`define PRIORITY_WIDTH_MSB 22
`define PRIORITY_WIDTH_LSB 21
`define SET_REVISION_MSB 20
`define SET_REVISION_LSB 18
`define MCU_EXTENSION_BIT 17
`define EXCEPTION_SET_BIT 16
`define SET_AVAILABILITY_MSB 15
`define SET_AVAILABILITY_LSB 14
`define USER_THREAD_BIT 13
`define TRACE_PRESENT_BIT 8
`define EXT_CONTROLLER_BIT 6
`define VECTORED_BIT 5

// Field values
`define PRIORITY_WIDTH_EIGHT 2'h1
`define PRIORITY_WIDTH_SIX 2'h0
`define SET_REVISION_ONE 3'h0

// Bits that may ever read as one, per variant
`define FULL_IMPL_MASK 32'h807fe160
`define MINIMAL_IMPL_MASK 32'h80000160

// Priority level bit positions in the status and cause words
`define STATUS_LEVEL_MSB 18
`define STATUS_LEVEL_SECOND 16
`define CAUSE_LEVEL_MSB 17
`define CAUSE_LEVEL_SECOND 16
`define LEVEL_LOW_LSB 10

`endif

// ### rtl/capability_pkg.sv
package capability_pkg;

    typedef enum logic {
        VARIANT_FULL = 1'b0,
        VARIANT_MINIMAL = 1'b1
    } variant_t;

    typedef enum logic [1:0] {
        SET_BASE_ONLY = 2'h0,
        SET_COMPRESSED_ONLY = 2'h1,
        SET_BOTH_BASE_BOOT = 2'h2,
        SET_BOTH_COMPRESSED_BOOT = 2'h3
    } set_availability_t;

    // Gray sequence along the start-up path
    typedef enum logic [1:0] {
        ST_RESET = 2'h0,
        ST_CAPTURE = 2'h1,
        ST_READY = 2'h3
    } start_state_t;

endpackage

// ### rtl/priority_level_assembler.sv
`timescale 1ns/10ps
module priority_level_assembler #(
    parameter int MSB_POS = 18,
    parameter int SECOND_POS = 16,
    parameter int LOW_LSB = 10
) (
    input wire logic [31:0] source_word,
    input wire logic eight_wide,
    output logic [7:0] level
);
    // Low six bits are contiguous; the two upper bits sit apart
    always_comb begin
        if (eight_wide) begin
            level = {source_word[MSB_POS], source_word[SECOND_POS],
                     source_word[LOW_LSB+5:LOW_LSB]};
        end else begin
            level = {2'h0, source_word[LOW_LSB+5:LOW_LSB]};
        end
    end
endmodule // priority_level_assembler

// ### rtl/capability_word_composer.sv
`timescale 1ns/10ps
`include "capability_map.svh"
module capability_word_composer (
    input wire capability_pkg::variant_t variant,
    input wire logic priority_eight,
    input wire logic mcu_present,
    input wire logic exception_compressed,
    input wire capability_pkg::set_availability_t set_availability,
    input wire logic user_thread_present,
    input wire logic trace_present,
    output logic [31:0] word
);
    import capability_pkg::*;

    always_comb begin
        word = 32'h0;
        word[`NEXT_PRESENT_BIT] = 1'b1;
        word[`TRACE_PRESENT_BIT] = trace_present;
        word[`EXT_CONTROLLER_BIT] = 1'b1;
        word[`VECTORED_BIT] = 1'b1;
        if (variant == VARIANT_FULL) begin
            word[`PRIORITY_WIDTH_MSB:`PRIORITY_WIDTH_LSB] =
                priority_eight ? `PRIORITY_WIDTH_EIGHT : `PRIORITY_WIDTH_SIX;
            word[`SET_REVISION_MSB:`SET_REVISION_LSB] = `SET_REVISION_ONE;
            word[`MCU_EXTENSION_BIT] = mcu_present;
            word[`EXCEPTION_SET_BIT] = exception_compressed;
            word[`SET_AVAILABILITY_MSB:`SET_AVAILABILITY_LSB] = set_availability;
            word[`USER_THREAD_BIT] = user_thread_present;
        end
        // Everything outside the variant's mask stays zero
        if (variant == VARIANT_FULL) begin
            word = word & `FULL_IMPL_MASK;
        end else begin
            word = word & `MINIMAL_IMPL_MASK;
        end
    end
endmodule // capability_word_composer

// ### rtl/capability_register_three_unit.sv
`timescale 1ns/10ps
`include "capability_map.svh"
module capability_register_three_unit #(
    parameter capability_pkg::variant_t VARIANT = capability_pkg::VARIANT_FULL
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cop_read,
    input wire logic cop_write,
    input wire logic [4:0] cop_reg_num,
    input wire logic [2:0] cop_reg_sel,
    input wire logic [31:0] cop_wdata,
    output logic cop_ready,
    output logic cop_rvalid,
    output logic [31:0] cop_rdata,
    output logic cop_wack,
    input wire logic cfg_priority_eight,
    input wire logic cfg_mcu_present,
    input wire logic cfg_exception_compressed,
    input wire capability_pkg::set_availability_t cfg_set_availability,
    input wire logic cfg_user_thread_present,
    input wire logic cfg_trace_present,
    input wire logic [31:0] status_word,
    input wire logic [31:0] cause_word,
    output logic [7:0] status_priority_level,
    output logic [7:0] requested_priority_level,
    output logic [31:0] capability_word
);
    import capability_pkg::*;

    start_state_t state;
    logic priority_eight;
    logic mcu_present;
    logic exception_compressed;
    set_availability_t set_availability;
    logic user_thread_present;
    logic trace_present;
    logic eight_wide;
    logic hit;
    logic read_hit;
    logic [31:0] next_capability_word;
    logic [7:0] next_status_level;
    logic [7:0] next_requested_level;

    assign hit = (cop_reg_num == `CAP3_REG_NUM) && (cop_reg_sel == `CAP3_REG_SEL);
    assign cop_ready = (state == ST_READY);
    // Minimal variant has no width field, so levels stay six bits there
    assign eight_wide = (VARIANT == VARIANT_FULL) && priority_eight;

    // Straps are sampled once, on the first edge after reset release
    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= ST_RESET;
        end else begin
            case (state)
                ST_RESET: begin
                    state <= ST_CAPTURE;
                end
                ST_CAPTURE: begin
                    state <= ST_READY;
                end
                ST_READY: begin
                    state <= ST_READY;
                end
                default: begin
                    state <= ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            priority_eight <= 1'b0;
            mcu_present <= 1'b0;
            exception_compressed <= 1'b0;
            set_availability <= SET_BASE_ONLY;
            user_thread_present <= 1'b0;
            trace_present <= 1'b0;
        end else if (state == ST_RESET) begin
            priority_eight <= cfg_priority_eight;
            mcu_present <= cfg_mcu_present;
            exception_compressed <= cfg_exception_compressed;
            set_availability <= cfg_set_availability;
            user_thread_present <= cfg_user_thread_present;
            trace_present <= cfg_trace_present;
        end
    end

    capability_word_composer composer (
        .variant(VARIANT),
        .priority_eight(priority_eight),
        .mcu_present(mcu_present),
        .exception_compressed(exception_compressed),
        .set_availability(set_availability),
        .user_thread_present(user_thread_present),
        .trace_present(trace_present),
        .word(next_capability_word)
    );

    // Loaded once; cop_wdata never reaches it, so software cannot alter it
    always_ff @(posedge mclk) begin
        if (rst) begin
            capability_word <= 32'h0;
        end else if (state == ST_CAPTURE) begin
            capability_word <= next_capability_word;
        end
    end

    // Reads answer one cycle later; other addresses in the space read zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            cop_rvalid <= 1'b0;
            cop_rdata <= 32'h0;
            read_hit <= 1'b0;
        end else begin
            cop_rvalid <= cop_read && cop_ready;
            if (cop_read && cop_ready) begin
                cop_rdata <= hit ? capability_word : 32'h0;
                read_hit <= hit;
            end
        end
    end

    // Writes are acknowledged and dropped
    always_ff @(posedge mclk) begin
        if (rst) begin
            cop_wack <= 1'b0;
        end else begin
            cop_wack <= cop_write && cop_ready;
        end
    end

    priority_level_assembler #(
        .MSB_POS(`STATUS_LEVEL_MSB),
        .SECOND_POS(`STATUS_LEVEL_SECOND),
        .LOW_LSB(`LEVEL_LOW_LSB)
    ) status_assembler (
        .source_word(status_word),
        .eight_wide(eight_wide),
        .level(next_status_level)
    );

    priority_level_assembler #(
        .MSB_POS(`CAUSE_LEVEL_MSB),
        .SECOND_POS(`CAUSE_LEVEL_SECOND),
        .LOW_LSB(`LEVEL_LOW_LSB)
    ) cause_assembler (
        .source_word(cause_word),
        .eight_wide(eight_wide),
        .level(next_requested_level)
    );

    always_ff @(posedge mclk) begin
        if (rst) begin
            status_priority_level <= 8'h0;
            requested_priority_level <= 8'h0;
        end else begin
            status_priority_level <= next_status_level;
            requested_priority_level <= next_requested_level;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    logic answer_hit;
    assign answer_hit = cop_rvalid && read_hit;

    sequence s_read_request;
        cop_read && cop_ready && hit;
    endsequence

    sequence s_read_answer;
        ##1 (cop_rvalid && read_hit);
    endsequence

    sequence s_write_request;
        cop_write && cop_ready && !cop_read;
    endsequence

    a_top_bit_set: assert property (
        s_read_request |-> s_read_answer ##0 cop_rdata[`NEXT_PRESENT_BIT])
        else $error("capability top bit not one");

    a_width_field_code: assert property (
        answer_hit |-> cop_rdata[`PRIORITY_WIDTH_MSB:`PRIORITY_WIDTH_LSB] ==
            (eight_wide ? `PRIORITY_WIDTH_EIGHT : `PRIORITY_WIDTH_SIX))
        else $error("priority width field wrong");

    // Release edge still loads the reset level, so it is left out
    a_status_level_high: assert property (
        !rst && eight_wide |=> status_priority_level[7:6] ==
            {$past(status_word[`STATUS_LEVEL_MSB]),
             $past(status_word[`STATUS_LEVEL_SECOND])})
        else $error("status level upper bits wrong");

    a_status_level_six: assert property (
        !rst && !eight_wide |=> status_priority_level ==
            {2'h0, $past(status_word[`LEVEL_LOW_LSB+5:`LEVEL_LOW_LSB])})
        else $error("six-bit status level wrong");

    a_cause_level_high: assert property (
        !rst && eight_wide |=> requested_priority_level[7:6] ==
            {$past(cause_word[`CAUSE_LEVEL_MSB]),
             $past(cause_word[`CAUSE_LEVEL_SECOND])})
        else $error("requested level upper bits wrong");

    a_cause_level_six: assert property (
        !rst && !eight_wide |=> requested_priority_level ==
            {2'h0, $past(cause_word[`LEVEL_LOW_LSB+5:`LEVEL_LOW_LSB])})
        else $error("six-bit requested level wrong");

    a_revision_release_one: assert property (
        answer_hit |->
            cop_rdata[`SET_REVISION_MSB:`SET_REVISION_LSB] == `SET_REVISION_ONE)
        else $error("compressed set revision not release one");

    a_mcu_extension_bit: assert property (
        answer_hit |-> cop_rdata[`MCU_EXTENSION_BIT] ==
            ((VARIANT == VARIANT_FULL) && mcu_present))
        else $error("microcontroller extension bit wrong");

    a_exception_set_bit: assert property (
        answer_hit |-> cop_rdata[`EXCEPTION_SET_BIT] ==
            ((VARIANT == VARIANT_FULL) && exception_compressed))
        else $error("exception entry set bit wrong");

    a_set_availability: assert property (
        answer_hit && (VARIANT == VARIANT_FULL) |->
            cop_rdata[`SET_AVAILABILITY_MSB:`SET_AVAILABILITY_LSB] == set_availability)
        else $error("instruction set availability wrong");

    a_user_thread_bit: assert property (
        answer_hit |-> cop_rdata[`USER_THREAD_BIT] ==
            ((VARIANT == VARIANT_FULL) && user_thread_present))
        else $error("user thread register bit wrong");

    a_trace_present_bit: assert property (
        answer_hit |-> cop_rdata[`TRACE_PRESENT_BIT] == trace_present)
        else $error("trace present bit wrong");

    a_ext_controller_one: assert property (
        s_read_request |-> s_read_answer ##0 cop_rdata[`EXT_CONTROLLER_BIT])
        else $error("external controller bit not one");

    a_vectored_one: assert property (
        s_read_request |-> s_read_answer ##0 cop_rdata[`VECTORED_BIT])
        else $error("vectored interrupt bit not one");

    a_full_unimpl_zero: assert property (
        answer_hit && (VARIANT == VARIANT_FULL) |->
            (cop_rdata & ~`FULL_IMPL_MASK) == 32'h0)
        else $error("unimplemented bits not zero");

    a_minimal_fields_only: assert property (
        answer_hit && (VARIANT == VARIANT_MINIMAL) |->
            (cop_rdata & ~`MINIMAL_IMPL_MASK) == 32'h0)
        else $error("minimal variant reports extra bits");

    a_word_stays_fixed: assert property (
        (state == ST_READY) ##1 (state == ST_READY) |-> $stable(capability_word))
        else $error("capability word changed after start-up");

    a_write_then_read: assert property (
        s_write_request ##1 s_read_request |->
            s_read_answer ##0 (cop_rdata == $past(capability_word, 2)))
        else $error("write altered reported value");

    a_write_acked: assert property (
        cop_write && cop_ready |=> cop_wack)
        else $error("write acknowledge missing");

    a_read_answer_next: assert property (
        cop_read && cop_ready |=> cop_rvalid)
        else $error("read answer missing");

    a_no_answer_unasked: assert property (
        !rst && !(cop_read && cop_ready) |=> !cop_rvalid)
        else $error("read answer without a taken read");

    a_unmapped_reads_zero: assert property (
        cop_read && cop_ready && !hit |=> cop_rdata == 32'h0)
        else $error("unmapped read not zero");

    a_refused_before_ready: assert property (
        !rst && !cop_ready |=> !cop_rvalid && !cop_wack)
        else $error("request answered before ready");

    a_startup_ready: assert property (
        $fell(rst) |-> !cop_ready ##1 !cop_ready ##1 cop_ready)
        else $error("ready not raised two edges after release");

endmodule // capability_register_three_unit

// ### tb/capability_register_three_unit_tb_top.sv
`timescale 1ns/10ps
module capability_register_three_unit_tb_top;
    import capability_pkg::*;
    logic mclk;
    logic rst;
    logic cop_read;
    logic cop_write;
    logic [4:0] cop_reg_num;
    logic [2:0] cop_reg_sel;
    logic [31:0] cop_wdata;
    logic [31:0] status_word;
    logic [31:0] cause_word;
    // Straps packed: eight, mcu, exception set, availability[1:0], user thread, trace
    logic [6:0] straps;
    logic [6:0] kept;
    logic ready [2];
    logic rvalid [2];
    logic wack [2];
    logic [31:0] rdata [2];
    logic [31:0] word [2];
    logic [7:0] slev [2];
    logic [7:0] rlev [2];
    int num_errors = 0;
    int tests_run = 0;
    int seed = 32'h5c9fd7bb;

    // Index 0 is the full variant, index 1 the minimal one
    for (genvar g = 0; g < 2; g++) begin : g_dut
        capability_register_three_unit #(.VARIANT(variant_t'(g))) dut (
            .mclk(mclk),
            .rst(rst),
            .cop_read(cop_read),
            .cop_write(cop_write),
            .cop_reg_num(cop_reg_num),
            .cop_reg_sel(cop_reg_sel),
            .cop_wdata(cop_wdata),
            .cop_ready(ready[g]),
            .cop_rvalid(rvalid[g]),
            .cop_rdata(rdata[g]),
            .cop_wack(wack[g]),
            .cfg_priority_eight(straps[6]),
            .cfg_mcu_present(straps[5]),
            .cfg_exception_compressed(straps[4]),
            .cfg_set_availability(set_availability_t'(straps[3:2])),
            .cfg_user_thread_present(straps[1]),
            .cfg_trace_present(straps[0]),
            .status_word(status_word),
            .cause_word(cause_word),
            .status_priority_level(slev[g]),
            .requested_priority_level(rlev[g]),
            .capability_word(word[g])
        );
    end

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    function automatic logic [31:0] exp_word(input int m);
        logic [31:0] w;
        w = 32'h80000160;
        w[8] = kept[0];
        if (m == 0) begin
            w[22:21] = {1'b0, kept[6]};
            w[17] = kept[5];
            w[16] = kept[4];
            w[15:14] = kept[3:2];
            w[13] = kept[1];
        end
        return w;
    endfunction

    // Minimal variant keeps six-bit levels whatever the strap says
    function automatic logic [7:0] exp_level(input int m, input logic [31:0] w, input int msb);
        if (m == 0 && kept[6] === 1'b1)
            return {w[msb], w[16], w[15:10]};
        return {2'b00, w[15:10]};
    endfunction

    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_level(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_flag(input string n, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Request held through start-up so refusal while not ready is exercised
    task automatic do_reset(input logic [6:0] s);
        @(posedge mclk);
        rst <= 1'b1;
        cop_read <= 1'b1;
        cop_write <= 1'b1;
        cop_reg_num <= 5'h10;
        cop_reg_sel <= 3'h3;
        straps <= s;
        kept = s;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        for (int m = 0; m < 2; m++) begin
            chk_flag("ready in reset", 1'b0, ready[m]);
            chk_flag("rvalid in reset", 1'b0, rvalid[m]);
            chk_word("word in reset", 32'h0, word[m]);
            chk_word("rdata in reset", 32'h0, rdata[m]);
        end
        @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
        for (int m = 0; m < 2; m++)
            chk_flag("ready edge1", 1'b0, ready[m]);
        @(posedge mclk);
        cop_read <= 1'b0;
        cop_write <= 1'b0;
        repeat (2) begin
            @(negedge mclk);
            for (int m = 0; m < 2; m++) begin
                chk_flag("ready", 1'b1, ready[m]);
                chk_flag("rvalid before ready", 1'b0, rvalid[m]);
                chk_flag("wack before ready", 1'b0, wack[m]);
            end
        end
    endtask

    task automatic bus_op(input logic rd, input logic wr, input logic [4:0] num,
                          input logic [2:0] sel);
        @(posedge mclk);
        cop_read <= rd;
        cop_write <= wr;
        cop_reg_num <= num;
        cop_reg_sel <= sel;
        cop_wdata <= $random(seed);
        @(posedge mclk);
        cop_read <= 1'b0;
        cop_write <= 1'b0;
        @(negedge mclk);
        for (int m = 0; m < 2; m++) begin
            chk_flag("rvalid", rd, rvalid[m]);
            chk_flag("wack", wr, wack[m]);
        end
        @(negedge mclk);
        for (int m = 0; m < 2; m++) begin
            chk_flag("rvalid pulse", 1'b0, rvalid[m]);
            chk_flag("wack pulse", 1'b0, wack[m]);
        end
    endtask

    task automatic run_set(input logic [6:0] s);
        do_reset(s);
        for (int m = 0; m < 2; m++)
            chk_word("capability_word", exp_word(m), word[m]);
        // Straps moved after start-up must not leak into the word
        @(posedge mclk);
        straps <= 7'($random(seed));
        bus_op(1'b1, 1'b0, 5'h10, 3'h3);
        for (int m = 0; m < 2; m++)
            chk_word("rdata", exp_word(m), rdata[m]);
        bus_op(1'b0, 1'b1, 5'h10, 3'h3);
        bus_op(1'b1, 1'b1, 5'h10, 3'h3);
        for (int m = 0; m < 2; m++) begin
            chk_word("rdata after write", exp_word(m), rdata[m]);
            chk_word("word after write", exp_word(m), word[m]);
        end
        // Write taken on one edge, read of the same word on the next
        @(posedge mclk);
        cop_write <= 1'b1;
        cop_wdata <= $random(seed);
        @(posedge mclk);
        cop_write <= 1'b0;
        cop_read <= 1'b1;
        @(negedge mclk);
        for (int m = 0; m < 2; m++)
            chk_flag("wack back to back", 1'b1, wack[m]);
        @(posedge mclk);
        cop_read <= 1'b0;
        @(negedge mclk);
        for (int m = 0; m < 2; m++) begin
            chk_flag("rvalid back to back", 1'b1, rvalid[m]);
            chk_word("rdata back to back", exp_word(m), rdata[m]);
        end
        bus_op(1'b1, 1'b0, 5'h10, 3'h2);
        for (int m = 0; m < 2; m++)
            chk_word("rdata unmapped sel", 32'h0, rdata[m]);
        bus_op(1'b1, 1'b0, 5'h11, 3'h3);
        for (int m = 0; m < 2; m++)
            chk_word("rdata unmapped num", 32'h0, rdata[m]);
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            status_word <= (i == 0) ? 32'h00050000 : $random(seed);
            cause_word <= (i == 0) ? 32'h00030000 : $random(seed);
            @(posedge mclk);
            @(negedge mclk);
            for (int m = 0; m < 2; m++) begin
                chk_level("status level", exp_level(m, status_word, 18), slev[m]);
                chk_level("requested level", exp_level(m, cause_word, 17), rlev[m]);
            end
        end
        $display("test strap set %h done", s);
    endtask

    initial begin
        rst = 1'b1;
        cop_read = 1'b0;
        cop_write = 1'b0;
        cop_reg_num = 5'h0;
        cop_reg_sel = 3'h0;
        cop_wdata = 32'h0;
        status_word = 32'h0;
        cause_word = 32'h0;
        straps = 7'h0;
        kept = 7'h0;
        run_set(7'h00);
        run_set(7'h7f);
        for (int i = 0; i < 4; i++)
            run_set({1'b1, 1'b0, 1'b1, 2'(i), 1'b0, 1'b1});
        for (int i = 0; i < 6; i++)
            run_set(7'($random(seed)));
        print_verdict();
    end

    // Each strap set takes about 44 cycles; generous margin
    initial begin
        repeat (5000) @(posedge mclk);
        num_errors++;
        $display("[ERR] watchdog expected finish seen timeout");
        print_verdict();
    end
endmodule // capability_register_three_unit_tb_top
